//--- hw/phsp_defines.vh
// Constants for the PCM highway serial port.
`ifndef PHSP_DEFINES_VH
`define PHSP_DEFINES_VH
`define PHSP_FRAME_NS 125000
`define PHSP_CLK_NS 10
`define PHSP_FRAME_CYC (`PHSP_FRAME_NS / `PHSP_CLK_NS)
`define PHSP_SETTLE_FRAMES 4'h2
`define PHSP_DELAY_SHORT 3'h2
`define PHSP_DELAY_LONG 3'h6
`define PHSP_LEN_16K 4'h2
`define PHSP_LEN_24K 4'h3
`define PHSP_LEN_32K 4'h4
`define PHSP_LEN_PCM 4'h8
`define PHSP_RATE_16K 2'h0
`define PHSP_RATE_24K 2'h1
`define PHSP_RATE_32K 2'h2
`define PHSP_RATE_PCM 2'h3
`define PHSP_MU_ZERO 8'hff
`define PHSP_A_ZERO 8'hd5
`define PHSP_SIGN_BIT 7
`endif

//--- hw/phsp_port.v
// Serial voice data port facing a time-multiplexed PCM highway.
`include "phsp_defines.vh"

// Function
// RQ1: Long frame: drive output from frame pulse rise while pulse stays high.
// RQ2: Long frame: first bit launched by frame pulse AND bit clock.
// RQ3: Drive for 2, 3, 4 or 8 bit cycles less half, to mid LSB.
// RQ4: Pulse high on two consecutive falling edges means long format.
// RQ5: Encode rate chosen each frame from transmit pulse length.
// RQ6: Word for a request is output two frames after the request.
// RQ7: Delay-select adds four frames to the rate request only, six total.
// RQ8: Exactly one encode and one decode strobe per frame.
// RQ9: Output stays released for two frame pulses after reset or power-down.
// RQ10: Each frame pulse decides afresh the format of the next pulse.
// RQ11: Long receive: sample on falling edges while pulse high, store word.
// RQ12: Decode rate from receive pulse length, may change each frame.
// RQ13: Codec mode, long frame: 8-bit words as if pulses lasted eight cycles.
// RQ14: Short frame only for 32 kbps, or codec mode.
// RQ15: Pulse high on exactly one falling edge means short format.
// RQ16: Short frame: drive from next rising edge, release three and a half later.
// RQ17: Short receive: capture four bits on the next four falling edges.
// RQ18: Codec mode short frame: eight bits, fourth full, eighth half period.
// RQ19: The switch keeps one frame format between power-down cycles.
// RQ20: Idle PCM words follow the selected companding law zero code.
// RQ21: Receiver works with the transmitter's pulse and clock in loop.
// RQ22: Received ADPCM is decoded by the external G.726 engine.
// RQ23: Outside a word window the data output stays released.
module phsp_port #(
	parameter DW = 8
) (
	input wire clk,
	input wire rst_b,
	input wire tx_frame_pulse,
	input wire tx_bit_clock,
	input wire rx_frame_pulse,
	input wire rx_bit_clock,
	input wire rx_serial_in,
	input wire power_down,
	input wire codec_mode,
	input wire a_law_sel,
	input wire delay_sel,
	input wire [DW-1:0] enc_word,
	input wire enc_word_valid,
	output reg tx_serial_out_o,
	output reg tx_serial_out_oe,
	output reg enc_strobe,
	output reg [1:0] enc_rate,
	output reg dec_strobe,
	output reg [1:0] dec_rate,
	output reg [DW-1:0] dec_word,
	output reg short_format
);
	wire tfs_s;
	wire tbc_s;
	wire rfs_s;
	wire rbc_s;
	wire rdi_s;
	reg tbc_d_r;
	reg rbc_d_r;
	reg tfs_d_r;

	phsp_sync2 u_tfs (.clk(clk), .rst_b(rst_b), .d(tx_frame_pulse),
		.q(tfs_s));
	phsp_sync2 u_tbc (.clk(clk), .rst_b(rst_b), .d(tx_bit_clock),
		.q(tbc_s));
	phsp_sync2 u_rfs (.clk(clk), .rst_b(rst_b), .d(rx_frame_pulse),
		.q(rfs_s));
	phsp_sync2 u_rbc (.clk(clk), .rst_b(rst_b), .d(rx_bit_clock),
		.q(rbc_s));
	phsp_sync2 u_rdi (.clk(clk), .rst_b(rst_b), .d(rx_serial_in),
		.q(rdi_s));

	wire t_rise = tbc_s & ~tbc_d_r;
	wire t_fall = ~tbc_s & tbc_d_r;
	wire r_fall = ~rbc_s & rbc_d_r;
	wire fs_rise = tfs_s & ~tfs_d_r;

	// Maps a pulse length in bit cycles onto a rate code.
	function [1:0] len2rate;
		input [3:0] len;
		begin
			case (len)
				`PHSP_LEN_16K: len2rate = `PHSP_RATE_16K;
				`PHSP_LEN_24K: len2rate = `PHSP_RATE_24K;
				`PHSP_LEN_32K: len2rate = `PHSP_RATE_32K;
				default: len2rate = `PHSP_RATE_PCM;
			endcase
		end
	endfunction

	// Maps a rate code onto the word length in bits.
	function [3:0] rate2len;
		input [1:0] rate;
		begin
			case (rate)
				`PHSP_RATE_16K: rate2len = `PHSP_LEN_16K;
				`PHSP_RATE_24K: rate2len = `PHSP_LEN_24K;
				`PHSP_RATE_32K: rate2len = `PHSP_LEN_32K;
				default: rate2len = `PHSP_LEN_PCM;
			endcase
		end
	endfunction

	// Transmit states, one-hot.
	localparam [3:0] TS_IDLE = 4'h1;
	localparam [3:0] TS_ARM = 4'h2;
	localparam [3:0] TS_SHIFT = 4'h4;
	localparam [3:0] TS_TAIL = 4'h8;

	reg [3:0] ts_r;
	reg [3:0] fs_len_r;
	reg [3:0] bit_cnt_r;
	reg [3:0] word_len_r;
	reg [DW-1:0] sh_r;
	reg [DW-1:0] pend_r;
	reg [DW-1:0] hold_r;
	reg [3:0] settle_r;
	reg long_r;
	reg fs_seen_r;
	reg [1:0] rq_pipe_r [0:5];
	integer i;

	wire settled = (settle_r == `PHSP_SETTLE_FRAMES);
	wire [1:0] req_rate = codec_mode ? `PHSP_RATE_PCM : len2rate(fs_len_r);
	wire [1:0] out_rate = delay_sel ? rq_pipe_r[5] : rq_pipe_r[1];
	wire [DW-1:0] idle_word = a_law_sel ? `PHSP_A_ZERO : `PHSP_MU_ZERO;

	// Frame pulse length counter and format decision per pulse.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fs_len_r <= 4'h0;
			long_r <= 1'b0;
			short_format <= 1'b0;
			fs_seen_r <= 1'b0;
			settle_r <= 4'h0;
		end else begin
			if (power_down) begin
				settle_r <= 4'h0; // RQ9
			end else if (fs_rise && !settled) begin
				settle_r <= settle_r + 4'h1; // RQ9
			end
			if (fs_rise) begin
				fs_len_r <= 4'h0;
				long_r <= 1'b0;
			end else if (t_fall && tfs_s) begin
				fs_len_r <= fs_len_r + 4'h1;
				if (fs_len_r != 4'h0) begin
					long_r <= 1'b1; // RQ4
				end
			end
			fs_seen_r <= tfs_s;
			if (fs_seen_r && !tfs_s) begin
				short_format <= ~long_r; // RQ10 RQ15
			end
		end
	end

	// Rate request pipeline, shifted once per frame at the pulse end.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (i = 0; i < 6; i = i + 1) begin
				rq_pipe_r[i] <= `PHSP_RATE_32K;
			end
			enc_strobe <= 1'b0;
			enc_rate <= `PHSP_RATE_32K;
			pend_r <= {DW{1'b1}};
			hold_r <= {DW{1'b1}};
		end else begin
			enc_strobe <= 1'b0;
			if (fs_seen_r && !tfs_s) begin
				rq_pipe_r[0] <= (long_r || codec_mode) ? req_rate
					: `PHSP_RATE_32K; // RQ5 RQ14
				for (i = 1; i < 6; i = i + 1) begin
					rq_pipe_r[i] <= rq_pipe_r[i-1]; // RQ7
				end
				enc_strobe <= 1'b1; // RQ8
				enc_rate <= delay_sel ? rq_pipe_r[4] : rq_pipe_r[0];
				hold_r <= pend_r; // RQ6
			end
			// A powered-down encoder leaves the law's zero code queued.
			if (power_down) begin
				pend_r <= idle_word; // RQ20
			end else if (enc_word_valid) begin
				pend_r <= enc_word;
			end
		end
	end

	// Transmit shifter: long frames start on pulse AND clock, short next rise.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ts_r <= TS_IDLE;
			bit_cnt_r <= 4'h0;
			word_len_r <= 4'h0;
			sh_r <= {DW{1'b0}};
			tx_serial_out_o <= 1'b0;
			tx_serial_out_oe <= 1'b0;
		end else begin
			case (ts_r)
				TS_IDLE: begin
					tx_serial_out_oe <= 1'b0; // RQ23
					if (fs_rise && settled) begin
						word_len_r <= codec_mode ? `PHSP_LEN_PCM
							: rate2len(out_rate); // RQ13
						sh_r <= hold_r;
						if (!short_format) begin
							tx_serial_out_oe <= 1'b1; // RQ1
							ts_r <= TS_ARM;
						end else begin
							ts_r <= TS_ARM;
						end
					end
				end
				TS_ARM: begin
					if (!short_format && tbc_s && tfs_s) begin
						tx_serial_out_o <= sh_r[DW-1]; // RQ2
						bit_cnt_r <= 4'h1;
						ts_r <= TS_SHIFT;
					end else if (short_format && t_rise && !tfs_s) begin
						tx_serial_out_oe <= 1'b1; // RQ16
						tx_serial_out_o <= sh_r[DW-1];
						bit_cnt_r <= 4'h1;
						ts_r <= TS_SHIFT;
					end
				end
				TS_SHIFT: begin
					if (t_rise) begin
						if (bit_cnt_r == word_len_r) begin
							ts_r <= TS_IDLE;
							tx_serial_out_oe <= 1'b0;
						end else begin
							sh_r <= {sh_r[DW-2:0], 1'b0};
							tx_serial_out_o <= sh_r[DW-2];
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
					end else if (t_fall && bit_cnt_r == word_len_r) begin
						ts_r <= TS_TAIL;
					end
				end
				TS_TAIL: begin
					tx_serial_out_oe <= 1'b0; // RQ3 RQ18
					ts_r <= TS_IDLE;
				end
				default: ts_r <= TS_IDLE;
			endcase
		end
	end

	// Receive states, one-hot.
	localparam [2:0] RS_IDLE = 3'h1;
	localparam [2:0] RS_LONG = 3'h2;
	localparam [2:0] RS_SHORT = 3'h4;

	reg [2:0] rs_r;
	reg [3:0] rcnt_r;
	reg [DW-1:0] rsh_r;
	reg rlong_r;

	// Receiver: counts falling edges while pulse high, or short four (eight in codec mode).
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rs_r <= RS_IDLE;
			rcnt_r <= 4'h0;
			rsh_r <= {DW{1'b0}};
			rlong_r <= 1'b0;
			dec_strobe <= 1'b0;
			dec_rate <= `PHSP_RATE_32K;
			dec_word <= {DW{1'b0}};
		end else begin
			dec_strobe <= 1'b0;
			case (rs_r)
				RS_IDLE: begin
					if (r_fall && rfs_s) begin
						rsh_r <= {rsh_r[DW-2:0], rdi_s}; // RQ11 RQ21
						rcnt_r <= 4'h1;
						rlong_r <= 1'b0;
						rs_r <= RS_LONG;
					end
				end
				RS_LONG: begin
					if (r_fall && rfs_s) begin
						rsh_r <= {rsh_r[DW-2:0], rdi_s}; // RQ11
						rcnt_r <= rcnt_r + 4'h1;
						rlong_r <= 1'b1;
					end else if (r_fall && !rlong_r) begin
						rsh_r <= {{(DW-1){1'b0}}, rdi_s}; // RQ17
						rcnt_r <= 4'h1;
						rs_r <= RS_SHORT;
					end else if (rlong_r && !rfs_s &&
							(!codec_mode || rcnt_r >= `PHSP_LEN_PCM)) begin
						dec_word <= rsh_r; // RQ11
						dec_rate <= codec_mode ? `PHSP_RATE_PCM
							: len2rate(rcnt_r); // RQ12 RQ13
						dec_strobe <= 1'b1; // RQ8 RQ22
						rs_r <= RS_IDLE;
					end else if (rlong_r && !rfs_s && r_fall) begin
						rsh_r <= {rsh_r[DW-2:0], rdi_s}; // RQ13
						rcnt_r <= rcnt_r + 4'h1;
					end
				end
				RS_SHORT: begin
					if (rcnt_r == (codec_mode ? `PHSP_LEN_PCM
							: `PHSP_LEN_32K)) begin
						dec_word <= rsh_r; // RQ17 RQ18
						dec_rate <= codec_mode ? `PHSP_RATE_PCM
							: `PHSP_RATE_32K; // RQ14
						dec_strobe <= 1'b1;
						rs_r <= RS_IDLE;
					end else if (r_fall) begin
						rsh_r <= {rsh_r[DW-2:0], rdi_s};
						rcnt_r <= rcnt_r + 4'h1;
					end
				end
				default: rs_r <= RS_IDLE;
			endcase
		end
	end

	// Edge history for the sampled clocks and transmit pulse.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tbc_d_r <= 1'b0;
			rbc_d_r <= 1'b0;
			tfs_d_r <= 1'b0;
		end else begin
			tbc_d_r <= tbc_s;
			rbc_d_r <= rbc_s;
			tfs_d_r <= tfs_s;
		end
	end

endmodule // phsp_port

//--- hw/phsp_sync2.v
// Two-stage synchroniser for one level from outside the clock domain.
module phsp_sync2 (
	input wire clk,
	input wire rst_b,
	input wire d,
	output reg q
);
	reg meta_r;

	// The first stage is read only by the second stage.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // phsp_sync2

//--- testbench/phsp_checker.sv
// Checker for the highway serial port.
module phsp_checker (
	input wire clk,
	input wire rst_b,
	input wire tx_frame_pulse,
	input wire rx_frame_pulse,
	input wire power_down,
	input wire tx_serial_out_oe,
	input wire enc_strobe,
	input wire dec_strobe,
	input wire short_format
);
	logic fp_r;
	logic [1:0] np_r;
	logic [7:0] id_r, on_r;
	// Counts pulses since power-down, cycles since pulse and cycles driven.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fp_r <= 1'b0;
			np_r <= 2'h0;
			id_r <= 8'h0;
			on_r <= 8'h0;
		end else begin
			fp_r <= tx_frame_pulse;
			if (power_down)
				np_r <= 2'h0;
			else if (tx_frame_pulse && !fp_r && np_r != 2'h3)
				np_r <= np_r + 2'h1;
			if (tx_frame_pulse)
				id_r <= 8'h0;
			else if (id_r != 8'hff)
				id_r <= id_r + 8'h1;
			on_r <= tx_serial_out_oe ? on_r + 8'h1 : 8'h0;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	settle_drive_a: assert property (tx_serial_out_oe |-> np_r > 2'h1)
		else $error("drive before settle");
	pd_release_a: assert property (power_down [*4] |-> !tx_serial_out_oe)
		else $error("drive in power down");
	enc_once_a: assert property (enc_strobe |=> !enc_strobe [*8])
		else $error("encode strobe repeats");
	dec_once_a: assert property (dec_strobe |=> !dec_strobe [*8])
		else $error("decode strobe repeats");
	drive_len_a: assert property (on_r < 8'd130)
		else $error("drive too long");
	idle_rel_a: assert property (tx_serial_out_oe |-> id_r < 8'd140)
		else $error("drive outside frame");
	fmt_pick_a: assert property ($changed(short_format) |-> !tx_frame_pulse)
		else $error("format changed in pulse");
	dec_after_a: assert property (dec_strobe |-> !rx_frame_pulse)
		else $error("decode before pulse end");
endmodule // phsp_checker
bind phsp_port phsp_checker u_chk (.clk(clk), .rst_b(rst_b),
	.tx_frame_pulse(tx_frame_pulse), .rx_frame_pulse(rx_frame_pulse),
	.power_down(power_down), .tx_serial_out_oe(tx_serial_out_oe),
	.enc_strobe(enc_strobe), .dec_strobe(dec_strobe),
	.short_format(short_format));

//--- testbench/phsp_switch.sv
// Model of the switch that clocks the highway.
module phsp_switch (
	output logic fp,
	output logic bclk,
	output logic rx_d,
	input wire tx_o,
	input wire tx_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	int nbits;
	wire line = tx_oe ? tx_o : 1'b1;
	initial begin
		fp = 1'b0;
		bclk = 1'b0;
		rx_d = 1'b0;
	end
	// One frame; len 0 is a short pulse. The clock stops between frames.
	task frame(input int len, input int bits, input logic [7:0] w);
		int i, k;
		nbits = 0;
		#3;
		fp = 1'b1;
		#20;
		for (i = 0; i < bits + (len == 0); i++) begin
			k = i - (len == 0);
			bclk = 1'b1;
			rx_d = k < 0 ? ~rx_d : w[bits - 1 - k];
			#62.5;
			bclk = 1'b0;
			nbits += tx_oe;
			// The pulse falls well after the clock edge that samples it.
			#31;
			if (i + 1 == (len == 0 ? 1 : len))
				fp = 1'b0;
			#31.5;
		end
		fp = 1'b0;
		rx_d = ~rx_d;
	endtask
endmodule // phsp_switch

//--- testbench/tb.sv
// Self-checking bench for the highway serial port.
`include "phsp_defines.vh"
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst_b, pd, cm, al, dsel;
	logic [7:0] ew;
	logic [1:0] rq;
	wire fp, bck, rxd, txo, toe, es, dst, sf;
	wire [1:0] er, dr;
	wire [7:0] dw;
	int errors, checked, cyc;
	phsp_switch sw (.fp(fp), .bclk(bck), .rx_d(rxd), .tx_o(txo),
		.tx_oe(toe));
	phsp_port dut (.clk(clk), .rst_b(rst_b), .tx_frame_pulse(fp),
		.tx_bit_clock(bck), .rx_frame_pulse(fp), .rx_bit_clock(bck),
		.rx_serial_in(rxd), .power_down(pd), .codec_mode(cm),
		.a_law_sel(al), .delay_sel(dsel), .enc_word(ew),
		.enc_word_valid(1'b1), .tx_serial_out_o(txo),
		.tx_serial_out_oe(toe), .enc_strobe(es), .enc_rate(er),
		.dec_strobe(dst), .dec_rate(dr), .dec_word(dw),
		.short_format(sf));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Keeps the latest encode rate and cuts a hang short.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (es === 1'b1)
			rq <= er;
		if (cyc == 30000) begin
			errors++;
			test_done;
		end
	end
	task check(input string n, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	function logic [1:0] rate(input int l);
		case (l)
			2: rate = `PHSP_RATE_16K;
			3: rate = `PHSP_RATE_24K;
			4: rate = `PHSP_RATE_32K;
			default: rate = `PHSP_RATE_PCM;
		endcase
	endfunction
	task send(input int len, input int bits, input logic [7:0] w);
		@(posedge clk);
		ew <= w;
		sw.frame(len, bits, w);
		repeat (40) @(posedge clk);
	endtask
	// Power-down pulse, then two frames with the line released.
	task settle(input int len, input int bits);
		@(posedge clk);
		pd <= 1'b1;
		al <= ~al;
		repeat (5) @(posedge clk);
		pd <= 1'b0;
		repeat (2) begin
			send(len, bits, 8'h00);
			check("settle bits", sw.nbits, 0);
		end
	endtask
	task t_long;
		int l[4];
		int i;
		l = '{2, 3, 4, 8};
		settle(2, 2);
		for (i = 0; i < 12; i++) begin
			send(l[i / 3], l[i / 3], 8'h96 + i);
			check("format", sf, 0);
			check("dec rate", dr, rate(l[i / 3]));
			if (i % 3 == 2) begin
				check("bits", sw.nbits, l[i / 3]);
				check("enc rate", rq, rate(l[i / 3]));
			end
		end
		check("dec word", dw, 8'ha1);
		$display("long frames done");
	endtask
	task t_delay;
		int i;
		@(posedge clk);
		dsel <= 1'b1;
		for (i = 0; i < 6; i++)
			send(i ? 8 : 2, i ? 8 : 2, 8'h11);
		check("delayed rate", rq, `PHSP_RATE_16K);
		@(posedge clk);
		dsel <= 1'b0;
		$display("delay done");
	endtask
	task t_short;
		settle(0, 4);
		repeat (3) send(0, 4, 8'h0c);
		check("format", sf, 1);
		check("bits", sw.nbits, 4);
		check("dec rate", dr, `PHSP_RATE_32K);
		check("dec word", dw[3:0], 4'hc);
		$display("short frames done");
	endtask
	task t_codec;
		@(posedge clk);
		cm <= 1'b1;
		repeat (2) send(0, 8, 8'ha5);
		check("bits", sw.nbits, 8);
		check("dec word", dw, 8'ha5);
		settle(2, 8);
		send(2, 8, 8'h3c);
		check("bits", sw.nbits, 8);
		check("dec word", dw, 8'h3c);
		$display("codec done");
	endtask
	task test_done;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		rst_b = 1'b0;
		pd = 1'b0;
		cm = 1'b0;
		al = 1'b0;
		dsel = 1'b0;
		ew = 8'h00;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		t_long;
		t_delay;
		t_short;
		t_codec;
		test_done;
	end
endmodule // tb
